// ===== dcsp_chk.sv
`timescale 1ns/10ps
// output relations watched at the top ports
module dcsp_chk (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic latch_pointer_reset_line_i,
  input wire logic [2:0] pix_select_o,
  input wire logic pix_use_prog_o,
  input wire logic [2:0] pix_preset_sel_o,
  input wire logic pix_out_en_o,
  input wire logic pix_osc_run_o,
  input wire logic pix_force_high_o,
  input wire logic [3:0] pix_post_div_o,
  input wire logic [6:0] pix_fb_div_o,
  input wire logic mem_out_en_o,
  input wire logic mem_osc_run_o,
  input wire logic mem_force_high_o,
  input wire logic word_loaded_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // latch line high long enough to pass both sync stages
  sequence latch_held;
    latch_pointer_reset_line_i [*5];
  endsequence
  chk_load_gap: assert property (word_loaded_o |=> !word_loaded_o [*8]) else $error("loads too close");
  chk_pix_high: assert property (pix_force_high_o == (!pix_osc_run_o && pix_out_en_o)) else $error("pix high");
  chk_mem_high: assert property (mem_force_high_o == (!mem_osc_run_o && mem_out_en_o)) else $error("mem high");
  chk_post_code: assert property (pix_post_div_o inside {4'h1, 4'h2, 4'h4, 4'h8}) else $error("post ratio");
  chk_div_nonzero: assert property (pix_fb_div_o != 7'h00) else $error("divider zero");
  chk_cfg_change: assert property ($changed(pix_fb_div_o) |-> word_loaded_o) else $error("stray update");
  chk_pix_prog: assert property (pix_use_prog_o |-> pix_select_o == 3'h2) else $error("pix mode");
  chk_sel_hold: assert property (latch_held |-> $stable(pix_select_o)) else $error("select moved");
  chk_sel_mirror: assert property (pix_preset_sel_o == pix_select_o) else $error("preset index");
endmodule // dcsp_chk
bind dcsp_top dcsp_chk i_dcsp_chk (.*);

// ===== dcsp_ctl_model.sv
`timescale 1ns/10ps
// display controller side: drives the select pins and the latch line
module dcsp_ctl_model (
  input wire logic mclk_i,
  output logic d_o,
  output logic wr_o,
  output logic s2_o,
  output logic le_o
);
  initial begin
    {d_o, wr_o, s2_o, le_o} = 4'h0;
  end
  // wait n clocks, then move just after the edge
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // latch low: the pins act as selects
  task automatic set_sel(input logic [2:0] s);
    le_o = 1'b0;
    {s2_o, wr_o, d_o} = s;
    step(8);
  endtask
  // raise latch line, then n bits lsb first, one per strobe rise
  task automatic send(input logic [19:0] w, input int n);
    le_o = 1'b1;
    step(4);
    for (int i = 0; i < n; i++) begin
      wr_o = 1'b0;
      d_o = w[i];
      step(4);
      wr_o = 1'b1;
      step(4);
    end
    d_o = ~d_o; // data past its hold time no longer shows the last bit
  endtask
endmodule // dcsp_ctl_model

// ===== dcsp_gen_bank.sv
`timescale 1ns/10ps
// settings of one generator, loaded when a word addresses it
module dcsp_gen_bank #(
  parameter logic GEN_SEL = 1'b1
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  dcsp_word_if.dst wif,
  output dcsp_pkg::dcsp_gen_cfg_t cfg_o
);
  import dcsp_pkg::*;
  dcsp_gen_cfg_t cfg_reg;
  dcsp_gen_cfg_t cfg_next;
  wire hit = wif.load && (wif.word[GEN_ADDR_POS] == GEN_SEL);
  // unpack fields of the word
  always_comb begin
    cfg_next = cfg_reg;
    if (hit) begin
      cfg_next.tristate = wif.word[TRISTATE_POS];
      cfg_next.osc_dis = wif.word[OSC_DIS_POS];
      cfg_next.fmode = wif.word[FMODE_POS];
      cfg_next.pdiv = wif.word[PDIV_LSB +: PDIV_W];
      cfg_next.fb_div = wif.word[FB_DIV_LSB +: DIV_W];
      cfg_next.ref_div = wif.word[REF_DIV_LSB +: DIV_W];
    end
  end
  // reset puts drivers on, oscillator on, preset mode
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_reg <= RST_CFG;
    end else begin
      cfg_reg <= cfg_next;
    end
  end
  assign cfg_o = cfg_reg;
endmodule // dcsp_gen_bank

// ===== dcsp_pkg.sv
package dcsp_pkg;
  // serial word geometry
  localparam int WORD_W = 20;
  localparam int PTR_W = 5;
  localparam int DIV_W = 7;
  localparam int PDIV_W = 2;
  // field positions inside the program word
  localparam int GEN_ADDR_POS = 0;
  localparam int TRISTATE_POS = 1;
  localparam int OSC_DIS_POS = 2;
  localparam int FMODE_POS = 3;
  localparam int PDIV_LSB = 4;
  localparam int FB_DIV_LSB = 6;
  localparam int REF_DIV_LSB = 13;
  // last pointer value before the automatic transfer
  localparam logic [4:0] PTR_LAST = 5'h13;
  // values after reset
  localparam logic RST_TRISTATE = 1'b0;
  localparam logic RST_OSC_DIS = 1'b0;
  localparam logic RST_FMODE = 1'b1;
  localparam logic [1:0] RST_PDIV = 2'h0;
  localparam logic [6:0] RST_DIV = 7'h01;
  // select code that lets the pixel generator use its programmed dividers
  localparam logic [2:0] PIX_EXT_SEL = 3'h2;
  // one generator's settings
  typedef struct packed {
    logic tristate;
    logic osc_dis;
    logic fmode;
    logic [PDIV_W-1:0] pdiv;
    logic [DIV_W-1:0] fb_div;
    logic [DIV_W-1:0] ref_div;
  } dcsp_gen_cfg_t;
  localparam dcsp_gen_cfg_t RST_CFG = '{RST_TRISTATE, RST_OSC_DIS, RST_FMODE, RST_PDIV, RST_DIV, RST_DIV};
endpackage : dcsp_pkg

// ===== dcsp_top.sv
`timescale 1ns/10ps
// Notes on behaviour
// - a 20-bit shift register loads via data and strobe while latch line high
// - rising latch line clears bit pointer; controller can write the next full word without one
// - each rising strobe while latch line high, except in the cycle latch rises, captures one data bit and advances pointer
// - after twenty bits the word loads the addressed generator automatically
// - pointer returns to zero after each full word
// - address bit one selects pixel generator, zero selects memory generator
// - tristate bit one floats the output driver, zero enables it
// - after reset both output drivers are enabled
// - oscillator-disable bit one powers the oscillator down, zero runs it
// - after reset both oscillators run
// - disabled oscillator with enabled driver holds output high
// - mode bit one picks presets, zero picks programmed dividers
// - pixel uses programmed dividers only if mode zero and selects low,high,low
// - memory generator mode ignores select inputs
// - after reset both generators use preset mode
// - post divider codes 0..3 divide by 1,2,4,8
// - word bits 6..12 hold the feedback divider
// - word bits 13..19 hold the reference divider
// - latch low: select latch transparent; latch high: select held, programming open
// - divider values zero and one both mean divide by one
module dcsp_top (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic select0_serial_in_i,
  input wire logic select1_write_strobe_i,
  input wire logic select2_input_i,
  input wire logic latch_pointer_reset_line_i,
  output logic [2:0] pix_select_o,
  output logic pix_use_prog_o,
  output logic [2:0] pix_preset_sel_o,
  output logic pix_out_en_o,
  output logic pix_osc_run_o,
  output logic pix_force_high_o,
  output logic [3:0] pix_post_div_o,
  output logic [dcsp_pkg::DIV_W-1:0] pix_fb_div_o,
  output logic [dcsp_pkg::DIV_W-1:0] pix_ref_div_o,
  output logic mem_use_prog_o,
  output logic mem_out_en_o,
  output logic mem_osc_run_o,
  output logic mem_force_high_o,
  output logic [3:0] mem_post_div_o,
  output logic [dcsp_pkg::DIV_W-1:0] mem_fb_div_o,
  output logic [dcsp_pkg::DIV_W-1:0] mem_ref_div_o,
  output logic word_loaded_o
);
  import dcsp_pkg::*;

  // two-stage synchronisers for the four pins
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      sync3_reg <= 4'h0;
    end else begin
      sync1_reg <= {latch_pointer_reset_line_i, select2_input_i, select1_write_strobe_i, select0_serial_in_i};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // synchronised levels and edges
  wire data_s = sync2_reg[0];
  wire strobe_s = sync2_reg[1];
  wire sel2_s = sync2_reg[2];
  wire latch_s = sync2_reg[3];
  wire strobe_rise = strobe_s && !sync3_reg[1];
  wire latch_rise = latch_s && !sync3_reg[3];

  // frequency-select latch: follows pins while latch line low
  logic [2:0] fs_reg;
  logic [2:0] fs_next;
  assign fs_next = latch_s ? fs_reg : {sel2_s, strobe_s, data_s};
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fs_reg <= 3'h0;
    end else begin
      fs_reg <= fs_next;
    end
  end

  // serial shifter with bit pointer
  logic [WORD_W-1:0] shift_reg;
  logic [WORD_W-1:0] shift_next;
  logic [PTR_W-1:0] ptr_reg;
  logic [PTR_W-1:0] ptr_next;
  logic load_reg;
  // delays the transfer pulse so it lines up with the output update
  logic load_d_reg;
  wire take_bit = latch_s && strobe_rise && !latch_rise;
  wire last_bit = take_bit && (ptr_reg == PTR_LAST);
  always_comb begin
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    if (latch_rise) begin
      ptr_next = '0;
    end else if (take_bit) begin
      shift_next[ptr_reg] = data_s;
      ptr_next = last_bit ? '0 : ptr_reg + PTR_W'(1);
    end
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_reg <= '0;
      ptr_reg <= '0;
      load_reg <= 1'b0;
      load_d_reg <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      load_reg <= last_bit;
      load_d_reg <= load_reg;
    end
  end

  // completed word goes to both banks; the address bit picks one
  dcsp_word_if wif ();
  assign wif.load = load_reg;
  assign wif.word = shift_reg;

  dcsp_gen_cfg_t pix_cfg;
  dcsp_gen_cfg_t mem_cfg;
  dcsp_gen_bank #(.GEN_SEL(1'b1)) u_pix_bank (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .wif(wif.dst),
    .cfg_o(pix_cfg)
  );
  dcsp_gen_bank #(.GEN_SEL(1'b0)) u_mem_bank (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .wif(wif.dst),
    .cfg_o(mem_cfg)
  );

  // divider helpers: zero treated as one, post code to ratio
  function automatic logic [DIV_W-1:0] div_eff(input logic [DIV_W-1:0] v);
    div_eff = (v == '0) ? DIV_W'(1) : v;
  endfunction
  function automatic logic [3:0] post_ratio(input logic [PDIV_W-1:0] c);
    post_ratio = 4'h1 << c;
  endfunction

  // pixel mode needs mode bit zero and select code low,high,low with latch high
  wire pix_prog = !pix_cfg.fmode && (fs_reg == PIX_EXT_SEL) && latch_s;
  wire mem_prog = !mem_cfg.fmode;

  // registered outputs
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pix_select_o <= 3'h0;
      pix_use_prog_o <= 1'b0;
      pix_preset_sel_o <= 3'h0;
      pix_out_en_o <= 1'b1;
      pix_osc_run_o <= 1'b1;
      pix_force_high_o <= 1'b0;
      pix_post_div_o <= 4'h1;
      pix_fb_div_o <= RST_DIV;
      pix_ref_div_o <= RST_DIV;
      mem_use_prog_o <= 1'b0;
      mem_out_en_o <= 1'b1;
      mem_osc_run_o <= 1'b1;
      mem_force_high_o <= 1'b0;
      mem_post_div_o <= 4'h1;
      mem_fb_div_o <= RST_DIV;
      mem_ref_div_o <= RST_DIV;
      word_loaded_o <= 1'b0;
    end else begin
      pix_select_o <= fs_reg;
      pix_use_prog_o <= pix_prog;
      pix_preset_sel_o <= fs_reg;
      pix_out_en_o <= !pix_cfg.tristate;
      pix_osc_run_o <= !pix_cfg.osc_dis;
      pix_force_high_o <= pix_cfg.osc_dis && !pix_cfg.tristate;
      pix_post_div_o <= post_ratio(pix_cfg.pdiv);
      pix_fb_div_o <= div_eff(pix_cfg.fb_div);
      pix_ref_div_o <= div_eff(pix_cfg.ref_div);
      mem_use_prog_o <= mem_prog;
      mem_out_en_o <= !mem_cfg.tristate;
      mem_osc_run_o <= !mem_cfg.osc_dis;
      mem_force_high_o <= mem_cfg.osc_dis && !mem_cfg.tristate;
      mem_post_div_o <= post_ratio(mem_cfg.pdiv);
      mem_fb_div_o <= div_eff(mem_cfg.fb_div);
      mem_ref_div_o <= div_eff(mem_cfg.ref_div);
      word_loaded_o <= load_d_reg;
    end
  end
endmodule // dcsp_top

// ===== dcsp_word_if.sv
`timescale 1ns/10ps
// carries a completed program word from the shifter to the generator banks
interface dcsp_word_if;
  import dcsp_pkg::*;
  logic load;
  logic [WORD_W-1:0] word;
  modport src (output load, output word);
  modport dst (input load, input word);
endinterface : dcsp_word_if

// ===== test_dcsp_top.sv
`timescale 1ns/10ps
// programs both generators through the pin model
module test_dcsp_top;
  logic mclk_i;
  logic rst_n_i;
  int err_total = 0;
  int n_tests = 0;
  int loads = 0;
  logic d, wr, s2, le, ppr, pen, prun, phi, mpr, men, mrun, mhi, wl;
  logic [2:0] psel, ppre;
  logic [3:0] ppd, mpd;
  logic [6:0] pfb, prf, mfb, mrf;
  dcsp_top i_dcsp_top (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .select0_serial_in_i(d), .select1_write_strobe_i(wr),
    .select2_input_i(s2), .latch_pointer_reset_line_i(le), .pix_select_o(psel), .pix_use_prog_o(ppr),
    .pix_preset_sel_o(ppre), .pix_out_en_o(pen), .pix_osc_run_o(prun), .pix_force_high_o(phi),
    .pix_post_div_o(ppd), .pix_fb_div_o(pfb), .pix_ref_div_o(prf), .mem_use_prog_o(mpr), .mem_out_en_o(men),
    .mem_osc_run_o(mrun), .mem_force_high_o(mhi), .mem_post_div_o(mpd), .mem_fb_div_o(mfb),
    .mem_ref_div_o(mrf), .word_loaded_o(wl));
  dcsp_ctl_model i_dcsp_ctl_model (.mclk_i(mclk_i), .d_o(d), .wr_o(wr), .s2_o(s2), .le_o(le));
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  // counts transfer pulses
  always @(posedge mclk_i) if (wl === 1'b1) loads++;
  task automatic chk(input logic [6:0] seen, input logic [6:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic t_reset;
    chk({pen, men, prun, mrun, phi, mhi}, 7'h3c);
    chk({ppr, mpr}, 0);
    chk(pfb, 1);
    chk(mpd, 1);
  endtask
  // abandoned partial word, pointer reset, then a pixel word
  task automatic t_pix;
    i_dcsp_ctl_model.set_sel(3'h2);
    i_dcsp_ctl_model.send(20'hfffff, 7);
    i_dcsp_ctl_model.set_sel(3'h2);
    i_dcsp_ctl_model.send(20'haa2f5, 20);
    i_dcsp_ctl_model.step(6);
    chk(loads[6:0], 1);
    chk({pen, prun, phi, ppr}, 4'hb);
    chk(ppd, 8);
    chk(pfb, 7'h0b);
    chk(prf, 7'h55);
    chk({men, mrun, mpr}, 3'h6);
  endtask
  // memory word straight after, with no pointer reset
  task automatic t_mem;
    i_dcsp_ctl_model.send(20'h00aa2, 20);
    i_dcsp_ctl_model.step(6);
    chk(loads[6:0], 2);
    chk({men, mrun, mhi, mpr}, 4'h5);
    chk(mpd, 4);
    chk(mfb, 7'h2a);
    chk(mrf, 1);
  endtask
  // new select code with latch low
  task automatic t_sel;
    i_dcsp_ctl_model.set_sel(3'h5);
    chk(psel, 3'h5);
    chk(ppre, 3'h5);
    chk({ppr, mpr}, 1);
    chk(loads[6:0], 2);
  endtask
  initial begin
    rst_n_i = 1'b0;
    repeat (8) @(posedge mclk_i);
    #1 rst_n_i = 1'b1;
    i_dcsp_ctl_model.step(3);
    t_reset();
    t_pix();
    t_mem();
    t_sel();
    tally_and_finish();
  end
  initial begin
    #100000;
    err_total++;
    tally_and_finish();
  end
  task automatic tally_and_finish;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
endmodule // test_dcsp_top
